// ===== rtl/bpsr_pkg.sv
// Purpose: Shared constants and carriers for the primary status register bank
// Assumes: Byte-addressed configuration access, 16-bit data path
// Notes: Offsets are configuration byte addresses
package bpsr_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] BPSR_OFF_COMMAND = 8'h04;
    localparam logic [7:0] BPSR_OFF_STATUS = 8'h06;
    localparam logic [7:0] BPSR_OFF_REVISION = 8'h08;
    // ==========================================================
    // Status field positions
    localparam int BPSR_BIT_DET_PAR = 15;
    localparam int BPSR_BIT_SIG_SYS = 14;
    localparam int BPSR_BIT_RCV_MABT = 13;
    localparam int BPSR_BIT_RCV_TABT = 12;
    localparam int BPSR_BIT_SIG_TABT = 11;
    localparam int BPSR_BIT_DEVSEL_LO = 9;
    localparam int BPSR_BIT_DATA_PAR = 8;
    localparam int BPSR_BIT_FAST_B2B = 7;
    localparam int BPSR_BIT_USER_FEAT = 6;
    localparam int BPSR_BIT_CAP66 = 5;
    localparam int BPSR_BIT_CAP_LIST = 4;
    // Command field positions
    localparam int BPSR_CMD_BIT_PAR_RESP = 6;
    localparam int BPSR_CMD_BIT_SYS_ERR_EN = 8;
    // ==========================================================
    // Fixed values and reset values
    localparam logic [1:0] BPSR_DEVSEL_MEDIUM = 2'h1;
    localparam logic [15:0] BPSR_STATUS_RESET = 16'h0290;
    localparam logic [15:0] BPSR_COMMAND_RESET = 16'h0000;
    localparam logic [15:0] BPSR_COMMAND_WMASK = 16'h0367;
    localparam logic [15:0] BPSR_STATUS_W1C_MASK = 16'hF900;
    // Arbitrary neutral revision value
    localparam logic [7:0] BPSR_REVISION_DEFAULT = 8'h5A;

    typedef struct packed {
        logic parityDetected;
        logic systemErrorDriven;
        logic masterAbortReceived;
        logic targetAbortReceived;
        logic targetAbortSignalled;
        logic parityPinSeen;
        logic busMasterPhase;
    } bpsr_events_s;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [15:0] wrData;
    } bpsr_cfg_s;
endpackage : bpsr_pkg

// ===== rtl/bpsr_flag.sv
// Purpose: One sticky write-one-to-clear status flag
// Assumes: Set and clear are single-cycle qualified strobes
// Notes: Set dominates clear in the same cycle
`timescale 1ns/1ps
module bpsr_flag (
    input wire logic refClk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic clkEn, // Freeze when low
    input wire logic setEvt, // Hardware event
    input wire logic clrReq, // Software write of one
    output logic flagQ // Sticky flag
);
    logic flag_d;
    logic flag_q;

    always_comb begin
        flag_d = flag_q;
        if (clkEn && setEvt) begin
            flag_d = 1'b1; // Event wins over a same-cycle clear
        end else if (clkEn && clrReq) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge refClk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flagQ = flag_q;
endmodule : bpsr_flag

// ===== rtl/bpsr_cmd_ctl.sv
// Purpose: Enable bits of the command register used by status logic
// Assumes: Write strobe already decoded for the command offset
// Notes: Only writable bits hold state, others read as zero
`timescale 1ns/1ps
module bpsr_cmd_ctl
    import bpsr_pkg::*;
(
    input wire logic refClk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic clkEn, // Freeze when low
    input wire logic wrEn, // Command write strobe
    input wire logic [15:0] wrData, // Write data
    output logic [15:0] cmdQ // Command value
);
    logic [15:0] cmd_d;
    logic [15:0] cmd_q;

    always_comb begin
        cmd_d = cmd_q;
        if (clkEn && wrEn) begin
            cmd_d = wrData & BPSR_COMMAND_WMASK;
        end
    end

    // Enables reset to disabled
    always_ff @(posedge refClk or negedge nrst) begin
        if (!nrst) begin
            cmd_q <= BPSR_COMMAND_RESET;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    assign cmdQ = cmd_q;
endmodule : bpsr_cmd_ctl

// ===== rtl/bpsr_regs.sv
// Purpose: Primary status and revision registers of a bridge header
// Assumes: Configuration accesses arrive synchronous to ref_clk, one per strobe
// Notes: Read data registered, valid the cycle after the read strobe
`timescale 1ns/1ps
// Contract
// - Writing 1 clears a status flag; writing 0 leaves it alone.
// - Bit 15 sets whenever a parity error is detected.
// - Bit 14 sets only when system error driver enabled and error driven.
// - Bit 13 sets when a bridge-initiated cycle ends in master abort.
// - Bit 12 sets when target abort ends a bridge-initiated cycle.
// - Bit 11 sets when the bridge ends a transaction with target abort.
// - Bits 10 to 9 read fixed 01b, medium select timing, unwritable.
// - Bit 8 sets on parity pin, bridge mastering, and response enabled.
// - Bit 7 reads 1, fast back-to-back target support.
// - Bit 6 reads 0, no user-definable features.
// - Bit 4 reads 1, capabilities list present.
// - Bits 3 to 0 read zero.
// - Read-only 8-bit revision identifier at offset 08h.
// - Command bit 6 enables parity response, zero after reset.
// - Command bit 8 enables the system error driver, zero after reset.
module bpsr_regs
    import bpsr_pkg::*;
#(
    parameter logic [7:0] REVISION = BPSR_REVISION_DEFAULT
) (
    input wire logic ref_clk, // Primary bus clock
    input wire logic nrst, // Async reset, active low
    input wire logic clkEn, // Freeze all state when low
    input wire bpsr_cfg_s cfg, // Configuration access
    input wire bpsr_events_s evt, // Error event strobes
    input wire logic high_speed_strap, // 66 MHz strap level
    output logic [15:0] rdData, // Registered read data
    output logic rdValid, // Read data valid pulse
    output logic [15:0] statusQ, // Live status view
    output logic parityRespEn, // Command parity response enable
    output logic sysErrEn // Command system error enable
);
    // ==========================================================
    // Address decode
    logic cmdWr;
    logic statusWr;
    logic [15:0] cmdQ;
    logic [4:0] flagSet;
    logic [4:0] flagClr;
    logic [4:0] flagVal;
    logic dataParFlag;
    logic strap_d;
    logic strap_q;
    logic [15:0] rd_d;
    logic [15:0] rd_q;
    logic rdv_d;
    logic rdv_q;

    always_comb begin
        cmdWr = 1'b0;
        statusWr = 1'b0;
        if (cfg.wrEn && cfg.addr == BPSR_OFF_COMMAND) begin
            cmdWr = 1'b1;
        end else if (cfg.wrEn && cfg.addr == BPSR_OFF_STATUS) begin
            statusWr = 1'b1;
        end
    end

    bpsr_cmd_ctl u_cmd (
        .refClk(ref_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .wrEn(cmdWr),
        .wrData(cfg.wrData),
        .cmdQ(cmdQ)
    );

    assign parityRespEn = cmdQ[BPSR_CMD_BIT_PAR_RESP];
    assign sysErrEn = cmdQ[BPSR_CMD_BIT_SYS_ERR_EN];

    // ==========================================================
    // Sticky error flags, index 4 down to 0 = bits 15 down to 11
    assign flagSet[4] = evt.parityDetected;
    assign flagSet[3] = evt.systemErrorDriven & sysErrEn;
    assign flagSet[2] = evt.masterAbortReceived;
    assign flagSet[1] = evt.targetAbortReceived;
    assign flagSet[0] = evt.targetAbortSignalled;
    assign flagClr = {5{statusWr}} & cfg.wrData[BPSR_BIT_DET_PAR:BPSR_BIT_SIG_TABT];

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            bpsr_flag u_flag (
                .refClk(ref_clk),
                .nrst(nrst),
                .clkEn(clkEn),
                .setEvt(flagSet[gi]),
                .clrReq(flagClr[gi]),
                .flagQ(flagVal[gi])
            );
        end
    endgenerate

    // All three conditions must coincide
    bpsr_flag u_data_par (
        .refClk(ref_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .setEvt(evt.parityPinSeen & evt.busMasterPhase & parityRespEn),
        .clrReq(statusWr & cfg.wrData[BPSR_BIT_DATA_PAR]),
        .flagQ(dataParFlag)
    );

    // ==========================================================
    // Strap sampled each cycle that clkEn is high; reset holds the low default
    always_comb begin
        strap_d = strap_q;
        if (clkEn) begin
            strap_d = high_speed_strap;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            strap_q <= 1'b0;
        end else begin
            strap_q <= strap_d;
        end
    end

    // ==========================================================
    // Status composition
    always_comb begin
        statusQ = 16'h0000; // Reserved low bits stay zero
        statusQ[BPSR_BIT_DET_PAR:BPSR_BIT_SIG_TABT] = flagVal;
        statusQ[BPSR_BIT_DEVSEL_LO+1:BPSR_BIT_DEVSEL_LO] = BPSR_DEVSEL_MEDIUM;
        statusQ[BPSR_BIT_DATA_PAR] = dataParFlag;
        statusQ[BPSR_BIT_FAST_B2B] = 1'b1;
        statusQ[BPSR_BIT_USER_FEAT] = 1'b0;
        statusQ[BPSR_BIT_CAP66] = strap_q;
        statusQ[BPSR_BIT_CAP_LIST] = 1'b1;
    end

    // ==========================================================
    // Read path; unmapped offsets return zero
    always_comb begin
        rd_d = rd_q;
        rdv_d = rdv_q;
        if (clkEn) begin
            rdv_d = cfg.rdEn;
            if (!cfg.rdEn) begin
                rd_d = rd_q;
            end else if (cfg.addr == BPSR_OFF_COMMAND) begin
                rd_d = cmdQ;
            end else if (cfg.addr == BPSR_OFF_STATUS) begin
                rd_d = statusQ;
            end else if (cfg.addr == BPSR_OFF_REVISION) begin
                rd_d = {8'h00, REVISION};
            end else begin
                rd_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_q <= 16'h0000;
            rdv_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            rdv_q <= rdv_d;
        end
    end

    assign rdData = rd_q;
    assign rdValid = rdv_q;
endmodule : bpsr_regs

// ===== dv/bpsr_regs_chk.sv
// Purpose: Port checks of the status bank
// Assumes: One clock, async active-low reset
// Notes: Bound from the bench top
`timescale 1ns/1ps
module bpsr_regs_chk
    import bpsr_pkg::*;
#(
    parameter logic [7:0] REVISION = BPSR_REVISION_DEFAULT
) (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic clkEn, // Enable
    input wire bpsr_cfg_s cfg, // Access
    input wire bpsr_events_s evt, // Events
    input wire logic high_speed_strap, // Strap
    input wire logic [15:0] rdData, // Read data
    input wire logic rdValid, // Read valid
    input wire logic [15:0] statusQ, // Status
    input wire logic parityRespEn, // Parity enable
    input wire logic sysErrEn // Error enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ==========================================
    // Assertions
    fixed_bits_a: assert property (
        (statusQ & 16'h06DF) == 16'h0290) else $error("fixed status bits wrong");
    strap_view_a: assert property (
        clkEn |=> statusQ[5] == $past(high_speed_strap)) else $error("strap bit wrong");
    parity_set_a: assert property (
        clkEn && evt.parityDetected |=> statusQ[15]) else $error("parity flag missed");
    sys_gate_a: assert property (
        $rose(statusQ[14]) |-> $past(clkEn && evt.systemErrorDriven && sysErrEn))
        else $error("system error flag without cause");
    abort_set_a: assert property (
        clkEn |=> ($past({evt.masterAbortReceived, evt.targetAbortReceived,
        evt.targetAbortSignalled}) & ~statusQ[13:11]) == 3'h0) else $error("abort flag missed");
    data_par_a: assert property (
        $rose(statusQ[8]) |-> $past(clkEn && evt.parityPinSeen && evt.busMasterPhase
        && parityRespEn)) else $error("data parity flag without cause");
    gated_set_a: assert property (
        clkEn |=> ($past({evt.systemErrorDriven && sysErrEn, evt.parityPinSeen
        && evt.busMasterPhase && parityRespEn}) & ~{statusQ[14], statusQ[8]}) == 2'h0)
        else $error("gated flag missed");
    w1c_clear_a: assert property (
        clkEn && cfg.wrEn && cfg.addr == BPSR_OFF_STATUS && evt == '0
        |=> (statusQ & BPSR_STATUS_W1C_MASK) == ($past(statusQ) & ~$past(cfg.wrData)
        & BPSR_STATUS_W1C_MASK)) else $error("status clear wrong");
    rd_status_a: assert property (
        clkEn && cfg.rdEn && cfg.addr == BPSR_OFF_STATUS
        |=> rdValid && rdData == $past(statusQ)) else $error("status read wrong");
    rd_rev_a: assert property (
        clkEn && cfg.rdEn && cfg.addr == BPSR_OFF_REVISION
        |=> rdData == {8'h00, REVISION}) else $error("revision read wrong");
    cover property (clkEn && cfg.wrEn && evt.masterAbortReceived);
    cover property ($rose(statusQ[8]));
    cover property (rdValid);
endmodule : bpsr_regs_chk

// ===== dv/bpsr_host.sv
// Purpose: Host issuing configuration accesses
// Assumes: Tasks are entered just after a rising edge
// Notes: Idle lines show inverted values, never the last one
`timescale 1ns/1ps
module bpsr_host
    import bpsr_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rdValid, // Read valid
    input wire logic [15:0] rdData, // Read data
    output bpsr_cfg_s cfg // Access
);
    initial cfg = '0;
    task automatic idleBus;
        cfg <= '{1'b0, 1'b0, ~cfg.addr, ~cfg.wrData};
    endtask : idleBus
    task automatic cfgWrite(input logic [7:0] a, input logic [15:0] d);
        cfg <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        idleBus();
        @(posedge ref_clk);
    endtask : cfgWrite
    task automatic cfgRead(input logic [7:0] a, output logic [15:0] d);
        cfg <= '{1'b0, 1'b1, a, cfg.wrData};
        @(posedge ref_clk);
        idleBus();
        #1;
        // No valid pulse means no data
        d = (rdValid === 1'b1) ? rdData : 16'hXXXX;
        @(posedge ref_clk);
    endtask : cfgRead
endmodule : bpsr_host

// ===== dv/bpsr_regs_tb.sv
// Purpose: Self-checking bench of the status bank
// Assumes: Accesses through the host model
// Notes: Revision overridden to show the parameter reaches the read path
`timescale 1ns/1ps
module bpsr_regs_tb;
    import bpsr_pkg::*;
    localparam logic [7:0] REV = 8'hC3; // Arbitrary value
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic high_speed_strap = 1'b1;
    bpsr_events_s evt = '0;
    bpsr_cfg_s cfg;
    logic [15:0] rdData, statusQ, got;
    logic rdValid, parityRespEn, sysErrEn;
    int mismatches = 0;
    int compares = 0;
    bpsr_regs #(.REVISION(REV)) dut_u (.ref_clk, .nrst, .clkEn, .cfg, .evt,
        .high_speed_strap, .rdData, .rdValid, .statusQ, .parityRespEn, .sysErrEn);
    bpsr_host host_u (.ref_clk, .rdValid, .rdData, .cfg);
    initial forever #2 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        host_u.cfgRead(a, got);
        chk(what, exp, got);
    endtask : rd
    task automatic pulse(input bpsr_events_s e);
        evt <= e;
        @(posedge ref_clk);
        evt <= '0;
        @(posedge ref_clk);
    endtask : pulse
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // ==========================================
    // Watchdog and main sequence
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(BPSR_OFF_STATUS, 16'h02B0, "status reset");
        chk("enables reset", 16'h0000, {14'h0, parityRespEn, sysErrEn});
        rd(BPSR_OFF_REVISION, {8'h00, REV}, "revision");
        host_u.cfgWrite(BPSR_OFF_REVISION, 16'hFFFF);
        host_u.cfgWrite(BPSR_OFF_STATUS, 16'hFFFF);
        rd(BPSR_OFF_REVISION, {8'h00, REV}, "revision kept");
        rd(BPSR_OFF_STATUS, 16'h02B0, "status kept");
        rd(8'h0A, 16'h0000, "unmapped");
        pulse(7'h23);
        rd(BPSR_OFF_STATUS, 16'h02B0, "gated events");
        host_u.cfgWrite(BPSR_OFF_COMMAND, 16'h0140);
        chk("enables set", 16'h0003, {14'h0, parityRespEn, sysErrEn});
        rd(BPSR_OFF_COMMAND, 16'h0140, "command readback");
        pulse(7'h02);
        rd(BPSR_OFF_STATUS, 16'h02B0, "pin without master");
        pulse(7'h7F);
        rd(BPSR_OFF_STATUS, 16'hFBB0, "all flags");
        clkEn <= 1'b0;
        host_u.cfgWrite(BPSR_OFF_STATUS, 16'hFFFF);
        clkEn <= 1'b1;
        rd(BPSR_OFF_STATUS, 16'hFBB0, "frozen write");
        host_u.cfgWrite(BPSR_OFF_STATUS, 16'h2000);
        rd(BPSR_OFF_STATUS, 16'hDBB0, "clear one");
        fork
            pulse(7'h10);
            host_u.cfgWrite(BPSR_OFF_STATUS, 16'h2000);
        join
        rd(BPSR_OFF_STATUS, 16'hFBB0, "set beats clear");
        host_u.cfgWrite(BPSR_OFF_STATUS, 16'hF900);
        rd(BPSR_OFF_STATUS, 16'h02B0, "all cleared");
        high_speed_strap <= 1'b0;
        @(posedge ref_clk);
        rd(BPSR_OFF_STATUS, 16'h0290, "strap low");
        // Mid-run reset must drop flags and enables
        pulse(7'h7F);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk("enables after reset", 16'h0000, {14'h0, parityRespEn, sysErrEn});
        rd(BPSR_OFF_STATUS, 16'h0290, "flags after reset");
        wrap_up();
    end
endmodule : bpsr_regs_tb
bind bpsr_regs bpsr_regs_chk #(.REVISION(REVISION)) chk_u (.ref_clk, .nrst, .clkEn, .cfg,
    .evt, .high_speed_strap, .rdData, .rdValid, .statusQ, .parityRespEn, .sysErrEn);
